// >>> rrt_pkg.sv
package rrt_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] RRT_NRT_HIGH_OFS = 8'h10;
	localparam logic [7:0] RRT_NRT_LOW_OFS = 8'h11;
	localparam logic [7:0] RRT_CTRL_OFS = 8'h12;
	localparam logic [7:0] RRT_GPT_HIGH_OFS = 8'h13;
	localparam logic [7:0] RRT_GPT_LOW_OFS = 8'h14;
	localparam logic [7:0] RRT_MODE_OFS = 8'h18;
	localparam logic [7:0] RRT_IRQ_STAT_OFS = 8'h19;
	localparam logic [7:0] RRT_IRQ_MASK_OFS = 8'h1a;
	localparam logic [7:0] RRT_CMD_OFS = 8'h1b;
	localparam logic [7:0] RRT_STATUS_OFS = 8'h1c;
	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int RRT_CTRL_NRT_STEP = 0;
	localparam int RRT_CTRL_NRT_PAY = 1;
	localparam int RRT_CTRL_NRT_PEER = 2;
	localparam int RRT_CTRL_MRT_STEP = 3;
	localparam int RRT_CTRL_TRIG_LSB = 5;
	// mode register fields
	localparam int RRT_MODE_NFC = 0;
	localparam int RRT_MODE_PEER = 1;
	// command register bits
	localparam int RRT_CMD_NRT_START = 0;
	localparam int RRT_CMD_GPT_START = 1;
	// interrupt bits
	localparam int RRT_IRQ_NRT = 0;
	localparam int RRT_IRQ_GPT = 1;
	localparam int RRT_IRQ_W = 2;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RRT_NRT_RESET = 8'h00;
	localparam logic [7:0] RRT_CTRL_RESET = 8'h00;
	localparam logic [7:0] RRT_GPT_RESET = 8'h00;
	// ----------------------------------------------------------------
	// step sizes in carrier periods
	// ----------------------------------------------------------------
	localparam int RRT_NRT_STEP_FINE = 64;
	localparam int RRT_NRT_STEP_COARSE = 4096;
	localparam int RRT_MRT_STEP_FINE = 64;
	localparam int RRT_MRT_STEP_COARSE = 512;
	localparam int RRT_GPT_STEP = 8;
	// ----------------------------------------------------------------
	// trigger source codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		RRT_TRIG_NONE = 3'h0,
		RRT_TRIG_RX_END = 3'h1,
		RRT_TRIG_RX_START = 3'h2,
		RRT_TRIG_TX_END = 3'h3
	} rrt_trig_t;
endpackage : rrt_pkg

// >>> rrt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module rrt_prescaler
	import rrt_pkg::*;
#(
	parameter int STEP = 64
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// control
	input wire logic carrier_tick_in,
	input wire logic clear_in,
	// tick
	output logic tick_out
);
	localparam int CW = $clog2(STEP);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} rrt_ps_state_t;

	rrt_ps_state_t st_reg;
	rrt_ps_state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (clear_in) begin
			st_next.cnt = '0;
		end else if (carrier_tick_in) begin
			if (st_reg.cnt == CW'(STEP - 1)) begin
				st_next.cnt = '0;
				st_next.tick = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_out = st_reg.tick;

	tick_single_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		tick_out |=> !tick_out) else $error("prescaler tick longer than one cycle");
endmodule : rrt_prescaler
`default_nettype wire

// >>> rrt_timer16.sv
`timescale 1ns/1ps
`default_nettype none
module rrt_timer16
	import rrt_pkg::*;
#(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// control
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic step_tick_in,
	input wire logic [W-1:0] limit_in,
	// status
	output logic running_out,
	output logic expired_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic run;
		logic exp;
	} rrt_tm_state_t;

	rrt_tm_state_t st_reg;
	rrt_tm_state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.exp = 1'b0;
		if (start_in) begin
			st_next.cnt = '0;
			st_next.run = 1'b1;
		end else if (stop_in) begin
			st_next.run = 1'b0;
		end else if (st_reg.run && step_tick_in) begin
			if (st_reg.cnt + W'(1) >= limit_in) begin
				st_next.run = 1'b0; // [R17]
				st_next.exp = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + W'(1); // [R17]
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign running_out = st_reg.run;
	assign expired_out = st_reg.exp;

	expire_stops_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		expired_out |-> !running_out) else $error("timer still running after expiry"); // [R17]
endmodule : rrt_timer16
`default_nettype wire

// >>> rrt_timers.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: the no-response timeout is 16 bits, high byte at 10h, low byte at 11h.
// R2: the no-response step is 64 carrier periods, or 4096 when its step bit is set.
// R3: the no-response timer starts after transmission and flags an interrupt on timeout.
// R4: in nfc mode the no-response timer starts only once an external field is seen.
// R5: in active peer mode it starts when the transmitter turns off after a message.
// R6: an all-zero no-response timeout never starts the timer.
// R7: the start command clears the no-response timer and counts the full timeout again.
// R8: control bit 2 picks own field off (0) or peer field on (1) as the peer-mode start; the code reads it only with trigger 011, else tx_end_in starts it.
// R9: control bit 1 selects the payment mode of the no-response timer.
// R10: control bit 3 sets the mask receive step to 64 or 512 carrier periods.
// R11: the general timer always starts on its direct command.
// R12: trigger 001 adds end of reception, 010 adds start of reception, 1xx is reserved.
// R13: trigger 011 adds end of transmission, and in peer mode turns the field off.
// R14: the general timeout is 16 bits at 13h and 14h in steps of 8 carrier periods.
// R15: the mask receive window after transmission ignores receiver output.
// R16: the general timer stops at its value and raises an expired event.
// R17: running timers count prescaled ticks and stop at expiry until restarted.
module rrt_timers
	import rrt_pkg::*;
#(
	parameter logic [7:0] MRT_VALUE = 8'h04
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// events
	input wire logic carrier_tick_in,
	input wire logic tx_end_in,
	input wire logic rx_start_in,
	input wire logic rx_end_in,
	input wire logic ext_field_in,
	input wire logic peer_field_on_in,
	// outputs
	output logic field_off_out,
	output logic rx_mask_out,
	output logic nrt_payment_out,
	output logic irq_out
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] nrt_hi;
		logic [7:0] nrt_lo;
		logic [7:0] ctrl;
		logic [7:0] gpt_hi;
		logic [7:0] gpt_lo;
		logic [1:0] mode;
		logic [RRT_IRQ_W-1:0] irq_stat;
		logic [RRT_IRQ_W-1:0] irq_mask;
		logic [7:0] rdata;
		logic nrt_armed;
		logic mrt_run;
		logic [7:0] mrt_cnt;
		logic field_off;
		logic irq;
	} rrt_state_t;

	rrt_state_t st_reg;
	rrt_state_t st_next;

	logic nrt_tick_f, nrt_tick_c, gpt_tick, mrt_tick_f, mrt_tick_c;
	logic nrt_run, nrt_exp, gpt_run, gpt_exp;
	logic nrt_start, nrt_stop, gpt_start;
	logic cmd_nrt, cmd_gpt, peer_mode, nfc_mode;
	logic [15:0] nrt_limit, gpt_limit;
	rrt_trig_t trig;

	// ----------------------------------------------------------------
	// prescalers
	// ----------------------------------------------------------------
	// no-response step, fine and coarse
	rrt_prescaler #(.STEP(RRT_NRT_STEP_FINE)) u_ps_nrt_f (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.carrier_tick_in(carrier_tick_in),
		.clear_in(nrt_start),
		.tick_out(nrt_tick_f)
	);
	rrt_prescaler #(.STEP(RRT_NRT_STEP_COARSE)) u_ps_nrt_c (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.carrier_tick_in(carrier_tick_in),
		.clear_in(nrt_start),
		.tick_out(nrt_tick_c)
	);
	// general timer step
	rrt_prescaler #(.STEP(RRT_GPT_STEP)) u_ps_gpt (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.carrier_tick_in(carrier_tick_in),
		.clear_in(gpt_start),
		.tick_out(gpt_tick)
	);
	// mask receive step, fine and coarse
	rrt_prescaler #(.STEP(RRT_MRT_STEP_FINE)) u_ps_mrt_f (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.carrier_tick_in(carrier_tick_in),
		.clear_in(tx_end_in),
		.tick_out(mrt_tick_f)
	);
	rrt_prescaler #(.STEP(RRT_MRT_STEP_COARSE)) u_ps_mrt_c (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.carrier_tick_in(carrier_tick_in),
		.clear_in(tx_end_in),
		.tick_out(mrt_tick_c)
	);

	// ----------------------------------------------------------------
	// start decisions
	// ----------------------------------------------------------------
	assign cmd_nrt = wr_in && addr_in == RRT_CMD_OFS && wdata_in[RRT_CMD_NRT_START];
	assign cmd_gpt = wr_in && addr_in == RRT_CMD_OFS && wdata_in[RRT_CMD_GPT_START];
	assign nrt_limit = {st_reg.nrt_hi, st_reg.nrt_lo}; // [R1]
	assign gpt_limit = {st_reg.gpt_hi, st_reg.gpt_lo}; // [R14]
	assign peer_mode = st_reg.mode[RRT_MODE_PEER];
	assign nfc_mode = st_reg.mode[RRT_MODE_NFC];
	assign trig = rrt_trig_t'(st_reg.ctrl[RRT_CTRL_TRIG_LSB +: 3]);

	always_comb begin
		logic want;
		want = 1'b0;
		if (peer_mode) begin
			if (trig == RRT_TRIG_TX_END && st_reg.ctrl[RRT_CTRL_NRT_PEER]) begin
				want = peer_field_on_in; // [R8] [R13]
			end else begin
				// field-off expiry only counts when the general timer owns the field
				want = (trig == RRT_TRIG_TX_END && gpt_exp) ||
					(trig != RRT_TRIG_TX_END && tx_end_in); // [R5] [R8]
			end
		end else if (nfc_mode) begin
			want = st_reg.nrt_armed && ext_field_in; // [R4]
		end else begin
			want = tx_end_in; // [R3]
		end
		nrt_start = (want || cmd_nrt) && nrt_limit != 16'h0000; // [R6] [R7]
	end

	assign nrt_stop = rx_start_in && !nrt_start; // response cancels the timeout [R3]

	always_comb begin
		gpt_start = cmd_gpt; // [R11]
		unique case (trig)
			RRT_TRIG_RX_END: gpt_start = cmd_gpt || rx_end_in; // [R12]
			RRT_TRIG_RX_START: gpt_start = cmd_gpt || rx_start_in; // [R12]
			RRT_TRIG_TX_END: gpt_start = cmd_gpt || tx_end_in; // [R13]
			default: gpt_start = cmd_gpt; // reserved codes add nothing [R12]
		endcase
	end

	// ----------------------------------------------------------------
	// timers
	// ----------------------------------------------------------------
	rrt_timer16 #(.W(16)) u_nrt (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.start_in(nrt_start),
		.stop_in(nrt_stop),
		.step_tick_in(st_reg.ctrl[RRT_CTRL_NRT_STEP] ? nrt_tick_c : nrt_tick_f), // [R2]
		.limit_in(nrt_limit),
		.running_out(nrt_run),
		.expired_out(nrt_exp)
	);
	// general timer runs to its limit, never cut short
	rrt_timer16 #(.W(16)) u_gpt (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.start_in(gpt_start),
		.stop_in(1'b0),
		.step_tick_in(gpt_tick),
		.limit_in(gpt_limit),
		.running_out(gpt_run),
		.expired_out(gpt_exp)
	);

	// ----------------------------------------------------------------
	// registers and next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.rdata = 8'h00;
		if (wr_in) begin
			unique case (addr_in)
				RRT_NRT_HIGH_OFS: st_next.nrt_hi = wdata_in; // [R1]
				RRT_NRT_LOW_OFS: st_next.nrt_lo = wdata_in; // [R1]
				RRT_CTRL_OFS: st_next.ctrl = wdata_in & 8'hef;
				RRT_GPT_HIGH_OFS: st_next.gpt_hi = wdata_in; // [R14]
				RRT_GPT_LOW_OFS: st_next.gpt_lo = wdata_in; // [R14]
				RRT_MODE_OFS: st_next.mode = wdata_in[1:0];
				RRT_IRQ_STAT_OFS: st_next.irq_stat = st_reg.irq_stat & ~wdata_in[RRT_IRQ_W-1:0];
				RRT_IRQ_MASK_OFS: st_next.irq_mask = wdata_in[RRT_IRQ_W-1:0];
				default: ;
			endcase
		end
		if (rd_in) begin
			unique case (addr_in)
				RRT_NRT_HIGH_OFS: st_next.rdata = st_reg.nrt_hi;
				RRT_NRT_LOW_OFS: st_next.rdata = st_reg.nrt_lo;
				RRT_CTRL_OFS: st_next.rdata = st_reg.ctrl;
				RRT_GPT_HIGH_OFS: st_next.rdata = st_reg.gpt_hi;
				RRT_GPT_LOW_OFS: st_next.rdata = st_reg.gpt_lo;
				RRT_MODE_OFS: st_next.rdata = {6'h00, st_reg.mode};
				RRT_IRQ_STAT_OFS: st_next.rdata = {6'h00, st_reg.irq_stat};
				RRT_IRQ_MASK_OFS: st_next.rdata = {6'h00, st_reg.irq_mask};
				RRT_STATUS_OFS: st_next.rdata = {4'h0, st_reg.field_off, st_reg.mrt_run,
					gpt_run, nrt_run};
				default: st_next.rdata = 8'h00;
			endcase
		end
		// nfc arm: end of tx arms, field seen starts
		if (tx_end_in) begin
			st_next.nrt_armed = 1'b1;
		end else if (nrt_start || !nfc_mode) begin
			st_next.nrt_armed = 1'b0;
		end
		// field off driven by general timer in peer mode
		if (peer_mode && trig == RRT_TRIG_TX_END && gpt_exp) begin
			st_next.field_off = 1'b1; // [R13]
		end else if (gpt_start || !peer_mode) begin
			st_next.field_off = 1'b0;
		end
		// mask receive window
		if (tx_end_in) begin
			st_next.mrt_run = MRT_VALUE != 8'h00; // [R15]
			st_next.mrt_cnt = 8'h00;
		end else if (st_reg.mrt_run && (st_reg.ctrl[RRT_CTRL_MRT_STEP] ? mrt_tick_c
			: mrt_tick_f)) begin // [R10]
			if (st_reg.mrt_cnt + 8'h01 >= MRT_VALUE) begin
				st_next.mrt_run = 1'b0;
			end else begin
				st_next.mrt_cnt = st_reg.mrt_cnt + 8'h01;
			end
		end
		// sticky interrupts, set wins over clear
		if (nrt_exp) begin
			st_next.irq_stat[RRT_IRQ_NRT] = 1'b1; // [R3]
		end
		if (gpt_exp) begin
			st_next.irq_stat[RRT_IRQ_GPT] = 1'b1; // [R16]
		end
		st_next.irq = |(st_next.irq_stat & ~st_next.irq_mask);
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_reg <= '0;
			st_reg.nrt_hi <= RRT_NRT_RESET;
			st_reg.nrt_lo <= RRT_NRT_RESET;
			st_reg.ctrl <= RRT_CTRL_RESET;
			st_reg.gpt_hi <= RRT_GPT_RESET;
			st_reg.gpt_lo <= RRT_GPT_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_out = st_reg.rdata;
	assign field_off_out = st_reg.field_off;
	assign rx_mask_out = st_reg.mrt_run; // [R15]
	assign nrt_payment_out = st_reg.ctrl[RRT_CTRL_NRT_PAY]; // [R9]
	assign irq_out = st_reg.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_nrt_expire;
		nrt_exp;
	endsequence
	nrt_irq_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		s_nrt_expire |=> st_reg.irq_stat[RRT_IRQ_NRT]) else $error("no-response flag missing"); // [R3]
	zero_no_start_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		nrt_limit == 16'h0000 |-> !nrt_start) else $error("zero timeout started"); // [R6]
	cmd_restart_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(cmd_nrt && nrt_limit != 16'h0000) |=> nrt_run) else $error("command restart lost"); // [R7]
	gpt_cmd_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		cmd_gpt |=> gpt_run) else $error("general timer ignored command"); // [R11]
	nfc_field_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(nfc_mode && !peer_mode && !ext_field_in && !cmd_nrt) |-> !nrt_start)
		else $error("nfc start without field"); // [R4]
	trig_rx_end_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(trig == RRT_TRIG_RX_END && rx_end_in) |=> gpt_run) else $error("rx end trigger lost"); // [R12]
	gpt_irq_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		gpt_exp |=> st_reg.irq_stat[RRT_IRQ_GPT]) else $error("timer flag missing"); // [R16]
	irq_level_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		irq_out == |(st_reg.irq_stat & ~st_reg.irq_mask)) else $error("irq level wrong");
	mask_open_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(tx_end_in && MRT_VALUE != 8'h00) |=> rx_mask_out) else $error("mask not opened"); // [R15]

	// ----------------------------------------------------------------
	// start, stop and field-off sources
	// ----------------------------------------------------------------
	sequence s_peer_field_start;
		peer_mode && trig == RRT_TRIG_TX_END && st_reg.ctrl[RRT_CTRL_NRT_PEER] &&
			peer_field_on_in && nrt_limit != 16'h0000;
	endsequence
	sequence s_peer_own_idle;
		peer_mode && trig == RRT_TRIG_TX_END && !st_reg.ctrl[RRT_CTRL_NRT_PEER] &&
			!cmd_nrt && !gpt_exp;
	endsequence
	sequence s_nrt_running;
		nrt_run;
	endsequence
	resp_stops_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(nrt_run && rx_start_in && !nrt_start) |=> !nrt_run) else $error("response ignored"); // [R3]
	reader_start_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(!peer_mode && !nfc_mode && tx_end_in && nrt_limit != 16'h0000) |=> s_nrt_running)
		else $error("tx end start lost"); // [R3]
	peer_tx_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(peer_mode && trig != RRT_TRIG_TX_END && tx_end_in && nrt_limit != 16'h0000)
		|=> s_nrt_running) else $error("peer tx off start lost"); // [R5]
	peer_field_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		s_peer_field_start |=> s_nrt_running) else $error("peer field start lost"); // [R8]
	peer_own_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		s_peer_own_idle |-> !nrt_start) else $error("early own field start"); // [R8]
	nfc_arm_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(nfc_mode && !peer_mode && st_reg.nrt_armed && ext_field_in && nrt_limit != 16'h0000)
		|=> s_nrt_running) else $error("nfc field start lost"); // [R4]
	field_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(peer_mode && trig == RRT_TRIG_TX_END && gpt_exp) |=> field_off_out)
		else $error("field not switched off"); // [R13]
	gpt_stops_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		gpt_exp |-> !gpt_run) else $error("general timer runs past expiry"); // [R16]
	trig_rx_start_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(trig == RRT_TRIG_RX_START && rx_start_in) |=> gpt_run) else $error("rx start lost"); // [R12]
	trig_tx_end_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(trig == RRT_TRIG_TX_END && tx_end_in) |=> gpt_run) else $error("tx end trigger lost"); // [R13]

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	rdata_idle_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!rd_in |=> rdata_out == 8'h00) else $error("read data outside read slot"); // [R1]
	ctrl_spare_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!st_reg.ctrl[4]) else $error("spare control bit set");
endmodule : rrt_timers
`default_nettype wire

// >>> rrt_timers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rrt_timers_tb_top
	import rrt_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and wiring
	// ----------------------------------------------------------------
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic carrier_tick_in = 1'b1;
	logic [3:0] ev_r = 4'h0;
	logic ext_field_in = 1'b0;
	logic [7:0] rdata_out;
	logic field_off_out;
	logic rx_mask_out;
	logic nrt_payment_out;
	logic irq_out;
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;
	int i;
	int e;
	logic [31:0] seed = 32'h2779a9e7;
	logic [7:0] v;
	logic [7:0] d;
	logic [7:0] g;
	logic [7:0] ofs [5] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14};

	rrt_timers #(.MRT_VALUE(8'h02)) rrt_timers_inst (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .carrier_tick_in(carrier_tick_in),
		.tx_end_in(ev_r[0]), .rx_start_in(ev_r[1]), .rx_end_in(ev_r[2]),
		.ext_field_in(ext_field_in), .peer_field_on_in(ev_r[3]), .field_off_out(field_off_out),
		.rx_mask_out(rx_mask_out), .nrt_payment_out(nrt_payment_out), .irq_out(irq_out)
	);

	always #4 clk_in = ~clk_in;

	always @(posedge clk_in) begin
		cyc++;
		if (cyc >= 60000) begin
			mismatches++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic rng(input string what, input int x, input int lo, input int hi);
		chk(what, 16'(x >= lo && x <= hi), 16'h0001);
	endtask : rng

	task automatic wr(input logic [7:0] a, input logic [7:0] dv);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= dv;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] dv);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		dv = rdata_out;
	endtask : rd

	task automatic pulse(input int k);
		@(posedge clk_in);
		ev_r[k] <= 1'b1;
		@(posedge clk_in);
		ev_r[k] <= 1'b0;
	endtask : pulse

	// cycles until irq_out, capped at lim
	task automatic wait_irq(input int lim, output int c);
		c = 0;
		while (c < lim) begin
			@(posedge clk_in);
			#1;
			c++;
			if (irq_out === 1'b1) break;
		end
	endtask : wait_irq

	task automatic mask_len(output int c);
		c = 0;
		#1;
		while (rx_mask_out === 1'b1 && c < 2000) begin
			@(posedge clk_in);
			#1;
			c++;
		end
	endtask : mask_len

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		for (i = 0; i < 3; i++) begin
			rd(ofs[i], d);
			chk("reset_val", d, 16'h0000);
		end
		for (i = 0; i < 5; i++) begin
			v = 8'(rnd());
			wr(ofs[i], v);
			rd(ofs[i], d);
			chk("reg_rw", d, (i == 2) ? (v & 8'hef) : v);
			if (i == 2) chk("payment", nrt_payment_out, v[1]);
		end
		rd(8'h20, d);
		chk("unmapped", d, 16'h0000);
		wr(8'h12, 8'h00);
		wr(8'h10, 8'h00);
		wr(8'h11, 8'h00);
		wr(8'h1b, 8'h01);
		wait_irq(300, n);
		chk("nrt_zero", irq_out, 1'b0);
		wr(8'h11, 8'h01);
		wr(8'h1b, 8'h01);
		wait_irq(200, n);
		rng("nrt_fine", n, 62, 68);
		wr(8'h19, 8'h03);
		wr(8'h1b, 8'h01);
		repeat (40) @(posedge clk_in);
		wr(8'h1b, 8'h01);
		wait_irq(200, n);
		rng("nrt_restart", n, 62, 68);
		wr(8'h19, 8'h03);
		wr(8'h12, 8'h01);
		wr(8'h1b, 8'h01);
		wait_irq(5000, n);
		rng("nrt_coarse", n, 4094, 4100);
		wr(8'h19, 8'h03);
		// response stops the timeout; mask window length per step
		wr(8'h12, 8'h00);
		wr(8'h11, 8'h04);
		pulse(0);
		mask_len(n);
		rng("mask_fine", n, 125, 131);
		pulse(1);
		wait_irq(400, n);
		chk("nrt_resp", irq_out, 1'b0);
		wr(8'h12, 8'h08);
		pulse(0);
		mask_len(n);
		rng("mask_coarse", n, 1021, 1027);
		chk("nrt_txend", irq_out, 1'b1);
		wr(8'h19, 8'h03);
		wr(8'h11, 8'h00);
		// general timer, direct start under three random trigger codes
		for (i = 0; i < 3; i++) begin
			g = 8'(rnd() % 6) + 8'h01;
			wr(8'h12, 8'(rnd()) & 8'he0);
			wr(8'h13, 8'h00);
			wr(8'h14, g);
			wr(8'h1b, 8'h02);
			wait_irq(200, n);
			rng("gpt_time", n, 8 * g - 1, 8 * g + 4);
			rd(8'h19, d);
			chk("gpt_stat", d, 16'h0002);
			wr(8'h19, 8'h03);
		end
		wr(8'h1a, 8'h02);
		wr(8'h1b, 8'h02);
		repeat (60) @(posedge clk_in);
		chk("irq_masked", irq_out, 1'b0);
		wr(8'h1a, 8'h00);
		#1;
		chk("irq_unmask", irq_out, 1'b1);
		wr(8'h19, 8'h02);
		#1;
		chk("irq_clear", irq_out, 1'b0);
		// trigger source table
		wr(8'h14, 8'h04);
		for (i = 0; i < 8; i++) begin
			for (e = 0; e < 3; e++) begin
				wr(8'h12, 8'(i << 5));
				pulse(e);
				rd(8'h1c, d);
				chk("trig", d[1], (i == 3 && e == 0) || (i == 2 && e == 1) ||
					(i == 1 && e == 2));
				repeat (150) @(posedge clk_in);
			end
		end
		wr(8'h19, 8'h03);
		// nfc mode waits for the external field
		wr(8'h12, 8'h00);
		wr(8'h11, 8'h01);
		wr(8'h18, 8'h01);
		pulse(0);
		repeat (100) @(posedge clk_in);
		chk("nfc_wait", irq_out, 1'b0);
		ext_field_in <= 1'b1;
		wait_irq(100, n);
		rng("nfc_start", n, 62, 70);
		ext_field_in <= 1'b0;
		wr(8'h19, 8'h03);
		// active peer mode starts
		wr(8'h18, 8'h02);
		pulse(0);
		wait_irq(100, n);
		rng("peer_txoff", n, 62, 70);
		wr(8'h19, 8'h03);
		wr(8'h14, 8'h02);
		wr(8'h12, 8'h64);
		pulse(0);
		repeat (30) @(posedge clk_in);
		chk("field_off", field_off_out, 1'b1);
		rd(8'h1c, d);
		chk("peer_wait", d[0], 1'b0);
		pulse(3);
		rd(8'h1c, d);
		chk("peer_on", d[0], 1'b1);
		repeat (100) @(posedge clk_in);
		wr(8'h19, 8'h03);
		wr(8'h12, 8'h60);
		pulse(0);
		rd(8'h1c, d);
		chk("own_wait", d[0], 1'b0);
		repeat (20) @(posedge clk_in);
		rd(8'h1c, d);
		chk("own_off", d & 8'h09, 16'h0009);
		wr(8'h18, 8'h00);
		repeat (2) @(posedge clk_in);
		#1;
		chk("field_on", field_off_out, 1'b0);
		wrap_up();
	end
endmodule : rrt_timers_tb_top
`default_nettype wire
